// ===== rtl/flash_seq_map.svh
// Function
// - Blocks hold up to 32K sixteen-bit words
// - Block maps to program or data space
// - Block base aligned to its own size
// - Reads complete without wait states
// - Up to eight separately erasable segments
// - Erase gives ones, write gives zeros
// - At most eight bits written per pulse
// - Clear targeted bits to zero before erase
// - Boost protected areas after partial write
// - Erase, inverse check, recovery, adjust pulse
// - Erase pulses of 5ms, repeated incrementally
// - Verify erase margin after each pulse
// - Inverse check first 32 words after verify
// - Recovery pulses only on depletion found
// - Recovery pulses hit all unprotected segments
// - Recovery pulse count capped per erase
// - Segment erase masks protected segments
// - Segment erase adds one write pulse
// - Program write pulses last 100us
// - Write-margin verify, rewrite failing bits only
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define FLASH_WORDS        32768
`define FLASH_SEGS         8
`define WRITE_MASK_BITS    8
`define INV_CHECK_WORDS    32
`define CLK_FREQ_HZ        25000000
`define CYCLES_PER_US      (`CLK_FREQ_HZ / 1000000)
`define ERASE_PULSE_US     5000
`define WRITE_PULSE_US     100
`define RECOVER_PULSE_US   100
`define PULSE_US_W         13
`endif

// ===== rtl/flash_seq_pkg.sv
package flash_seq_pkg;
   typedef enum logic [1:0] {op_program, op_erase, op_boost} op_t;
   typedef enum logic [1:0] {rd_normal, erase_margin_verify_mode, write_margin_verify_mode,
                             inverse_erase_mode} arr_mode_t;
   typedef enum logic [4:0] {st_idle, st_wchk, st_wboost, st_wvfy, st_wpulse_lo, st_wpulse_hi,
                             st_wnext, st_epulse, st_evfy, st_segw, st_inv, st_recover,
                             st_adjust} state_t;
endpackage

// ===== rtl/flash_pulse_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_pulse_timer (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   start,
   input  wire logic [`PULSE_US_W-1:0] len_us,
   input  wire logic [7:0]             cycles_per_us,
   output logic                        done
);
   logic                   running;
   logic [7:0]             pre;
   logic [`PULSE_US_W-1:0] left;
   logic                   next_running;
   logic [7:0]             next_pre;
   logic [`PULSE_US_W-1:0] next_left;
   logic                   next_done;
   logic                   tick;

   // The prescaler gives a one-cycle enable every microsecond of clock time.
   always_comb begin
      tick         = running && (pre == 8'h00);
      next_running = running;
      next_pre     = pre;
      next_left    = left;
      next_done    = 1'b0;
      if (start) begin
         next_running = 1'b1;
         next_pre     = cycles_per_us - 8'h01;
         next_left    = len_us;
      end else if (running) begin
         if (tick) begin
            next_pre  = cycles_per_us - 8'h01;
            next_left = left - `PULSE_US_W'(1);
            if (left <= `PULSE_US_W'(1)) begin
               next_running = 1'b0;
               next_done    = 1'b1;
            end
         end else begin
            next_pre = pre - 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         running <= 1'b0;
         pre     <= 8'h00;
         left    <= '0;
         done    <= 1'b0;
      end else begin
         running <= next_running;
         pre     <= next_pre;
         left    <= next_left;
         done    <= next_done;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/flash_erase_program_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_erase_program_sequencer
   import flash_seq_pkg::*;
#(
   parameter int WORDS            = `FLASH_WORDS,
   parameter int ERASE_PULSE_US   = `ERASE_PULSE_US,
   parameter int WRITE_PULSE_US   = `WRITE_PULSE_US,
   parameter int RECOVER_PULSE_US = `RECOVER_PULSE_US,
   parameter int AW               = $clog2(WORDS)
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    cmd_valid,
   input  wire op_t                     cmd_op,
   input  wire logic [`FLASH_SEGS-1:0]  cmd_seg_sel,
   input  wire logic [AW-1:0]           cmd_addr,
   input  wire logic [15:0]             cmd_data,
   input  wire logic [7:0]              cycles_per_us,
   input  wire logic [15:0]             erase_limit,
   input  wire logic [7:0]              recover_limit,
   input  wire logic [7:0]              write_limit,
   input  wire logic                    map_data_space,
   input  wire logic [15:0]             map_base,
   input  wire logic                    rd_req,
   input  wire logic                    rd_data_space,
   input  wire logic [15:0]             rd_addr,
   output logic [15:0]                  rd_data,
   output logic                         rd_valid,
   output logic                         busy,
   output logic                         done,
   output logic                         fail,
   input  wire logic [15:0]             arr_rdata,
   output logic [AW-1:0]                arr_addr,
   output arr_mode_t                    arr_mode,
   output logic                         arr_erase_pulse,
   output logic                         arr_write_pulse,
   output logic                         arr_fwrite_pulse,
   output logic [15:0]                  arr_zero_mask,
   output logic [`FLASH_SEGS-1:0]       arr_seg_en
);
   localparam int SW = $clog2(`FLASH_SEGS);
   localparam logic [AW-1:0] LAST_ADDR = AW'(WORDS - 1);
   localparam logic [AW-1:0] LAST_INV  = AW'(`INV_CHECK_WORDS - 1);
   localparam logic [15:0]   BLK_MASK  = 16'(WORDS - 1);

   state_t                  state, next_state;
   op_t                     op, next_op;
   logic [`FLASH_SEGS-1:0]  seg_sel, next_seg_sel;
   logic [15:0]             wdata, next_wdata;
   logic [15:0]             pend, next_pend;
   logic [7:0]              passes, next_passes;
   logic [15:0]             ecount, next_ecount;
   logic [7:0]              rcount, next_rcount;
   logic                    tmr_start, next_tmr_start;
   logic [`PULSE_US_W-1:0]  tmr_len, next_tmr_len;
   logic                    tmr_done;
   logic [15:0]             next_rd_data;
   logic                    next_rd_valid, next_done, next_fail;
   logic [AW-1:0]           next_arr_addr;
   arr_mode_t               next_arr_mode;
   logic [15:0]             next_arr_zero_mask;
   logic [`FLASH_SEGS-1:0]  next_arr_seg_en;
   logic                    targeted, last_word, partial, rd_hit;
   logic [15:0]             bits_left;

   flash_pulse_timer u_timer (
      .clk           (clk),
      .rst_n         (rst_n),
      .start         (tmr_start),
      .len_us        (tmr_len),
      .cycles_per_us (cycles_per_us),
      .done          (tmr_done)
   );

   always_comb begin
      // Boost walks the protected segments, clear walks the selected ones.
      targeted  = (op == op_boost) ? !seg_sel[arr_addr[AW-1 -: SW]] : seg_sel[arr_addr[AW-1 -: SW]];
      last_word = (arr_addr == LAST_ADDR);
      partial   = (seg_sel != '1);
      // A bit still to be cleared is one that should be zero but reads one.
      bits_left = ~wdata & arr_rdata;
      rd_hit    = (rd_data_space == map_data_space) && ((rd_addr & ~BLK_MASK) == (map_base & ~BLK_MASK));

      next_state         = state;
      next_op            = op;
      next_seg_sel       = seg_sel;
      next_wdata         = wdata;
      next_pend          = pend;
      next_passes        = passes;
      next_ecount        = ecount;
      next_rcount        = rcount;
      next_tmr_start     = 1'b0;
      next_tmr_len       = tmr_len;
      next_rd_data       = rd_data;
      next_rd_valid      = 1'b0;
      next_done          = 1'b0;
      next_fail          = fail;
      next_arr_addr      = arr_addr;
      next_arr_mode      = arr_mode;
      next_arr_zero_mask = 16'h0000;
      next_arr_seg_en    = '0;

      case (state)
         st_idle: begin
            next_arr_mode = rd_normal;
            if (cmd_valid) begin
               next_op      = cmd_op;
               next_seg_sel = cmd_seg_sel;
               next_fail    = 1'b0;
               next_ecount  = 16'h0000;
               next_rcount  = 8'h00;
               next_passes  = 8'h00;
               if (cmd_op == op_program) begin
                  next_wdata    = cmd_data;
                  next_arr_addr = cmd_addr;
                  next_arr_mode = write_margin_verify_mode;
                  next_state    = st_wvfy;
               end else begin
                  next_wdata    = 16'h0000;
                  next_arr_addr = '0;
                  next_state    = st_wchk;
               end
            end else if (rd_req && rd_hit) begin
               next_arr_addr = rd_addr[AW-1:0];
               next_rd_valid = 1'b1;
            end
            if (rd_valid) begin
               next_rd_data = arr_rdata;
            end
         end
         st_wchk: begin
            next_passes = 8'h00;
            if (targeted) begin
               next_arr_mode = (op == op_boost) ? rd_normal : write_margin_verify_mode;
               next_state    = (op == op_boost) ? st_wboost : st_wvfy;
            end else begin
               next_state = st_wnext;
            end
         end
         st_wboost: begin
            next_wdata    = arr_rdata;
            next_arr_mode = write_margin_verify_mode;
            next_state    = st_wvfy;
         end
         st_wvfy: begin
            if (bits_left == 16'h0000) begin
               next_state = (op == op_program) ? st_idle : st_wnext;
               next_done  = (op == op_program);
            end else if (passes >= write_limit) begin
               next_fail  = 1'b1;
               next_done  = 1'b1;
               next_state = st_idle;
            end else begin
               next_passes    = passes + 8'h01;
               next_pend      = bits_left;
               next_tmr_start = 1'b1;
               next_tmr_len   = `PULSE_US_W'(WRITE_PULSE_US);
               next_arr_mode  = rd_normal;
               if (bits_left[7:0] != 8'h00) begin
                  next_arr_zero_mask = {8'h00, bits_left[7:0]};
                  next_state         = st_wpulse_lo;
               end else begin
                  next_arr_zero_mask = {bits_left[15:8], 8'h00};
                  next_state         = st_wpulse_hi;
               end
            end
         end
         st_wpulse_lo: begin
            next_arr_zero_mask = {8'h00, pend[7:0]};
            if (tmr_done) begin
               next_arr_zero_mask = 16'h0000;
               if (pend[15:8] != 8'h00) begin
                  next_arr_zero_mask = {pend[15:8], 8'h00};
                  next_tmr_start     = 1'b1;
                  next_state         = st_wpulse_hi;
               end else begin
                  next_arr_mode = write_margin_verify_mode;
                  next_state    = st_wvfy;
               end
            end
         end
         st_wpulse_hi: begin
            next_arr_zero_mask = {pend[15:8], 8'h00};
            if (tmr_done) begin
               next_arr_zero_mask = 16'h0000;
               next_arr_mode      = write_margin_verify_mode;
               next_state         = st_wvfy;
            end
         end
         st_wnext: begin
            next_arr_mode = rd_normal;
            if (last_word) begin
               if (op == op_erase) begin
                  next_tmr_start  = 1'b1;
                  next_tmr_len    = `PULSE_US_W'(ERASE_PULSE_US);
                  next_arr_seg_en = seg_sel;
                  next_state      = st_epulse;
               end else begin
                  next_done  = 1'b1;
                  next_state = st_idle;
               end
            end else begin
               next_arr_addr = arr_addr + AW'(1);
               next_state    = st_wchk;
            end
         end
         st_epulse: begin
            next_arr_seg_en = seg_sel;
            if (tmr_done) begin
               next_arr_seg_en = '0;
               next_ecount     = ecount + 16'h0001;
               next_arr_addr   = '0;
               next_arr_mode   = erase_margin_verify_mode;
               next_state      = st_evfy;
            end
         end
         st_evfy: begin
            if (seg_sel[arr_addr[AW-1 -: SW]] && (arr_rdata != 16'hffff)) begin
               next_arr_mode = rd_normal;
               if (ecount >= erase_limit) begin
                  next_fail  = 1'b1;
                  next_done  = 1'b1;
                  next_state = st_idle;
               end else begin
                  next_tmr_start  = 1'b1;
                  next_arr_seg_en = seg_sel;
                  next_state      = st_epulse;
               end
            end else if (last_word) begin
               next_arr_addr = '0;
               if (partial) begin
                  next_arr_mode   = rd_normal;
                  next_tmr_start  = 1'b1;
                  next_tmr_len    = `PULSE_US_W'(RECOVER_PULSE_US);
                  next_arr_seg_en = seg_sel;
                  next_state      = st_segw;
               end else begin
                  next_arr_mode = inverse_erase_mode;
                  next_state    = st_inv;
               end
            end else begin
               next_arr_addr = arr_addr + AW'(1);
            end
         end
         st_segw: begin
            next_arr_seg_en = seg_sel;
            if (tmr_done) begin
               next_arr_seg_en = '0;
               next_arr_mode   = inverse_erase_mode;
               next_state      = st_inv;
            end
         end
         st_inv: begin
            next_tmr_len = `PULSE_US_W'(RECOVER_PULSE_US);
            if (arr_rdata != 16'hffff) begin
               next_arr_mode = rd_normal;
               if (rcount >= recover_limit) begin
                  next_fail  = 1'b1;
                  next_done  = 1'b1;
                  next_state = st_idle;
               end else begin
                  next_tmr_start  = 1'b1;
                  next_arr_seg_en = seg_sel;
                  next_state      = st_recover;
               end
            end else if (arr_addr == LAST_INV) begin
               next_arr_mode   = rd_normal;
               next_tmr_start  = 1'b1;
               next_arr_seg_en = seg_sel;
               next_state      = st_adjust;
            end else begin
               next_arr_addr = arr_addr + AW'(1);
            end
         end
         st_recover: begin
            next_arr_seg_en = seg_sel;
            if (tmr_done) begin
               next_arr_seg_en = '0;
               next_rcount     = rcount + 8'h01;
               next_arr_addr   = '0;
               next_arr_mode   = inverse_erase_mode;
               next_state      = st_inv;
            end
         end
         st_adjust: begin
            next_arr_seg_en = seg_sel;
            if (tmr_done) begin
               next_arr_seg_en = '0;
               next_done       = 1'b1;
               next_state      = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state            <= st_idle;
         op               <= op_program;
         seg_sel          <= '0;
         wdata            <= 16'h0000;
         pend             <= 16'h0000;
         passes           <= 8'h00;
         ecount           <= 16'h0000;
         rcount           <= 8'h00;
         tmr_start        <= 1'b0;
         tmr_len          <= '0;
         rd_data          <= 16'h0000;
         rd_valid         <= 1'b0;
         busy             <= 1'b0;
         done             <= 1'b0;
         fail             <= 1'b0;
         arr_addr         <= '0;
         arr_mode         <= rd_normal;
         arr_erase_pulse  <= 1'b0;
         arr_write_pulse  <= 1'b0;
         arr_fwrite_pulse <= 1'b0;
         arr_zero_mask    <= 16'h0000;
         arr_seg_en       <= '0;
      end else begin
         state            <= next_state;
         op               <= next_op;
         seg_sel          <= next_seg_sel;
         wdata            <= next_wdata;
         pend             <= next_pend;
         passes           <= next_passes;
         ecount           <= next_ecount;
         rcount           <= next_rcount;
         tmr_start        <= next_tmr_start;
         tmr_len          <= next_tmr_len;
         rd_data          <= next_rd_data;
         rd_valid         <= next_rd_valid;
         busy             <= (next_state != st_idle);
         done             <= next_done;
         fail             <= next_fail;
         arr_addr         <= next_arr_addr;
         arr_mode         <= next_arr_mode;
         arr_erase_pulse  <= (next_state == st_epulse);
         arr_write_pulse  <= ((next_state == st_wpulse_lo) || (next_state == st_wpulse_hi)) && !next_tmr_start;
         arr_fwrite_pulse <= (next_state == st_segw) || (next_state == st_recover) || (next_state == st_adjust);
         arr_zero_mask    <= next_arr_zero_mask;
         arr_seg_en       <= next_arr_seg_en;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/flash_erase_program_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module seq_checker
   import flash_seq_pkg::*;
#(
   parameter int WORDS          = 64,
   parameter int ERASE_PULSE_US = 5,
   parameter int WRITE_PULSE_US = 2,
   parameter int AW             = $clog2(WORDS)
) (
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          rd_req,
   input wire logic          busy,
   input wire logic          done,
   input wire logic          fail,
   input wire logic          rd_valid,
   input wire logic [15:0]   rd_data,
   input wire logic [15:0]   arr_rdata,
   input wire logic [AW-1:0] arr_addr,
   input wire arr_mode_t     arr_mode,
   input wire logic          arr_erase_pulse,
   input wire logic          arr_write_pulse,
   input wire logic          arr_fwrite_pulse,
   input wire logic [15:0]   arr_zero_mask,
   input wire logic [7:0]    arr_seg_en,
   input wire logic [7:0]    cycles_per_us
);
   logic [15:0] ewide, wwide, next_ewide, next_wwide;
   // Widths of the current erase and write pulses, in clocks.
   always_comb begin
      next_ewide = arr_erase_pulse ? ewide + 16'h0001 : 16'h0000;
      next_wwide = arr_write_pulse ? wwide + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ewide <= 16'h0000;
         wwide <= 16'h0000;
      end else begin
         ewide <= next_ewide;
         wwide <= next_wwide;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   mask_one_byte_a: assert property (arr_write_pulse |-> arr_zero_mask[15:8] == 8'h00 || arr_zero_mask[7:0] == 8'h00)
      else $error("write mask spans both bytes");
   erase_width_a: assert property ($fell(arr_erase_pulse) |-> ewide >= ERASE_PULSE_US * cycles_per_us)
      else $error("erase pulse too short");
   write_width_a: assert property ($fell(arr_write_pulse) |-> wwide >= WRITE_PULSE_US * cycles_per_us)
      else $error("write pulse too short");
   pulse_single_a: assert property ($onehot0({arr_erase_pulse, arr_write_pulse, arr_fwrite_pulse}))
      else $error("two pulse kinds at once");
   inv_window_a: assert property (arr_mode == inverse_erase_mode |-> arr_addr < 32)
      else $error("inverse check beyond word 31");
   seg_hold_a: assert property (arr_erase_pulse && $past(arr_erase_pulse) |-> $stable(arr_seg_en))
      else $error("segment enables moved during erase");
   read_idle_a: assert property (rd_valid |-> $past(rd_req) && !$past(busy))
      else $error("read answered without idle request");
   read_data_a: assert property (rd_valid |=> rd_data == $past(arr_rdata))
      else $error("read data not array word");
   done_pulse_a: assert property (done |-> !busy ##1 !done)
      else $error("done longer than one cycle");
   fail_end_a: assert property ($rose(fail) |-> done || $past(done))
      else $error("fail raised outside completion");
   cover property ($rose(arr_erase_pulse));
   cover property ($rose(arr_fwrite_pulse));
   cover property (rd_valid);
   cover property ($rose(fail));
endmodule
`default_nettype wire

// ===== testbench/flash_array_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_array_model
   import flash_seq_pkg::*;
#(
   parameter int WORDS = 64,
   parameter int AW    = $clog2(WORDS)
) (
   input  wire logic          clk,
   input  wire logic [AW-1:0] arr_addr,
   input  wire arr_mode_t     arr_mode,
   input  wire logic          arr_erase_pulse,
   input  wire logic          arr_write_pulse,
   input  wire logic          arr_fwrite_pulse,
   input  wire logic [15:0]   arr_zero_mask,
   input  wire logic [7:0]    arr_seg_en,
   input  wire logic [7:0]    erase_need,
   input  wire logic [7:0]    deplete_need,
   output logic [15:0]        arr_rdata
);
   logic [15:0] mem [WORDS];
   logic        pe, pw, pf;
   int          ecount, fcount;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      {pe, pw, pf} = 3'h0;
      ecount = 0;
      fcount = 0;
   end
   // Cells erase after erase_need pulses; depletion clears after deplete_need flash-writes.
   always @(negedge clk) begin
      if (arr_write_pulse && !pw) begin
         mem[arr_addr] = mem[arr_addr] & ~arr_zero_mask;
         ecount = 0;
      end
      if (arr_erase_pulse && !pe) begin
         ecount++;
         fcount = 0;
         if (ecount >= erase_need)
            foreach (mem[i]) if (arr_seg_en[i / (WORDS / 8)]) mem[i] = 16'hffff;
      end
      if (arr_fwrite_pulse && !pf) fcount++;
      {pe, pw, pf} = {arr_erase_pulse, arr_write_pulse, arr_fwrite_pulse};
   end
   assign arr_rdata = (arr_mode == inverse_erase_mode) ? ((fcount >= deplete_need) ? 16'hffff : 16'hfffe)
                                                       : mem[arr_addr];
endmodule
`default_nettype wire

// ===== testbench/flash_erase_program_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module flash_erase_program_sequencer_bench;
   import flash_seq_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, rd_req = 1'b0, rd_data_space = 1'b0, map_data_space = 1'b0;
   op_t cmd_op = op_program;
   logic [7:0] cmd_seg_sel = 8'hff, cycles_per_us = 8'h01, recover_limit = 8'h08, write_limit = 8'h04;
   logic [7:0] erase_need = 8'h01, deplete_need = 8'h00;
   logic [5:0] cmd_addr = 6'h00;
   logic [15:0] cmd_data = 16'h0000, erase_limit = 16'h0010, map_base = 16'h0040, rd_addr = 16'h0000;
   logic [15:0] rd_data, arr_rdata, arr_zero_mask;
   logic rd_valid, busy, done, fail, arr_erase_pulse, arr_write_pulse, arr_fwrite_pulse;
   logic [5:0] arr_addr;
   arr_mode_t arr_mode;
   logic [7:0] arr_seg_en;
   int bad_count = 0, n_checks = 0, e_cnt = 0, w_cnt = 0, f_cnt = 0, pre_w = 0;
   logic pe = 1'b0, pw = 1'b0, pf = 1'b0;
   always #20 clk = ~clk;
   flash_erase_program_sequencer #(.WORDS(64), .ERASE_PULSE_US(5), .WRITE_PULSE_US(2), .RECOVER_PULSE_US(2)) dut_u (
      .clk, .rst_n, .cmd_valid, .cmd_op, .cmd_seg_sel, .cmd_addr, .cmd_data, .cycles_per_us, .erase_limit,
      .recover_limit, .write_limit, .map_data_space, .map_base, .rd_req, .rd_data_space, .rd_addr, .rd_data,
      .rd_valid, .busy, .done, .fail, .arr_rdata, .arr_addr, .arr_mode, .arr_erase_pulse, .arr_write_pulse,
      .arr_fwrite_pulse, .arr_zero_mask, .arr_seg_en);
   flash_array_model #(.WORDS(64)) model_u (
      .clk, .arr_addr, .arr_mode, .arr_erase_pulse, .arr_write_pulse, .arr_fwrite_pulse, .arr_zero_mask,
      .arr_seg_en, .erase_need, .deplete_need, .arr_rdata);
   // Pulse starts per command; writes before the first erase pulse are the clear step.
   always @(posedge clk) begin
      #1;
      if (arr_erase_pulse && !pe) e_cnt++;
      if (arr_write_pulse && !pw) begin
         w_cnt++;
         if (e_cnt == 0) pre_w++;
      end
      if (arr_fwrite_pulse && !pf) f_cnt++;
      {pe, pw, pf} = {arr_erase_pulse, arr_write_pulse, arr_fwrite_pulse};
   end
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin bad_count++; $display("ERROR %0t word %h expected %h", $time, got, exp); end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin bad_count++; $display("ERROR %0t flag %b expected %b", $time, got, exp); end
   endtask
   task automatic chk_num(input int got, input int exp);
      n_checks++;
      if (got != exp) begin bad_count++; $display("ERROR %0t count %0d expected %0d", $time, got, exp); end
   endtask
   task automatic run_cmd(input op_t op, input logic [7:0] seg, input logic [5:0] a, input logic [15:0] d);
      int n;
      @(negedge clk);
      {cmd_op, cmd_seg_sel, cmd_addr, cmd_data, cmd_valid} = {op, seg, a, d, 1'b1};
      {e_cnt, w_cnt, f_cnt, pre_w} = {32'd0, 32'd0, 32'd0, 32'd0};
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
      if (n >= 20000) begin bad_count++; $display("ERROR %0t command never completed", $time); end
   endtask
   task automatic host_read(input logic sp, input logic [15:0] a, input logic hit, input logic [15:0] exp);
      @(negedge clk);
      {rd_req, rd_data_space, rd_addr} = {1'b1, sp, a};
      @(negedge clk);
      rd_req = 1'b0;
      chk_bit(rd_valid, hit);
      @(negedge clk);
      if (hit) chk_word(rd_data, exp);
   endtask
   task automatic t_reset();
      repeat (2) @(negedge clk);
      chk_word({busy, done, fail, rd_valid, arr_erase_pulse, arr_write_pulse, arr_fwrite_pulse}, 16'h0000);
      chk_bit(arr_mode == rd_normal, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_program();
      run_cmd(op_program, 8'hff, 6'h05, 16'h1234);
      chk_bit(fail, 1'b0);
      chk_num(w_cnt, 2);
      host_read(1'b0, 16'h0045, 1'b1, 16'h1234);
      run_cmd(op_program, 8'hff, 6'h05, 16'h1234);
      chk_num(w_cnt, 0);
      $display("test program done");
   endtask
   task automatic t_read_miss();
      host_read(1'b1, 16'h0045, 1'b0, 16'h0000);
      host_read(1'b0, 16'h0085, 1'b0, 16'h0000);
      $display("test read miss done");
   endtask
   task automatic t_erase_full();
      {erase_need, deplete_need} = {8'h03, 8'h02};
      run_cmd(op_erase, 8'hff, 6'h00, 16'h0000);
      chk_bit(fail, 1'b0);
      chk_bit(pre_w > 0, 1'b1);
      chk_num(e_cnt, 3);
      chk_num(f_cnt, 3);
      host_read(1'b0, 16'h0045, 1'b1, 16'hffff);
      $display("test full erase done");
   endtask
   task automatic t_seg_erase();
      run_cmd(op_program, 8'hff, 6'h09, 16'h5a5a);
      {erase_need, deplete_need} = {8'h01, 8'h00};
      run_cmd(op_erase, 8'h01, 6'h00, 16'h0000);
      chk_num(f_cnt, 2);
      host_read(1'b0, 16'h0049, 1'b1, 16'h5a5a);
      host_read(1'b0, 16'h0041, 1'b1, 16'hffff);
      $display("test segment erase done");
   endtask
   task automatic t_limits();
      {erase_need, erase_limit} = {8'h64, 16'h0003};
      run_cmd(op_erase, 8'hff, 6'h00, 16'h0000);
      chk_bit(fail, 1'b1);
      chk_num(e_cnt, 3);
      {erase_need, deplete_need, erase_limit, recover_limit} = {8'h01, 8'h0a, 16'h0010, 8'h02};
      run_cmd(op_erase, 8'hff, 6'h00, 16'h0000);
      chk_bit(fail, 1'b1);
      run_cmd(op_boost, 8'hfe, 6'h00, 16'h0000);
      chk_bit(fail, 1'b0);
      $display("test limits and boost done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #3000000;
      bad_count++;
      conclude();
   end
   initial begin
      t_reset();
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_program();
      t_read_miss();
      t_erase_full();
      t_seg_erase();
      t_limits();
      conclude();
   end
endmodule
bind flash_erase_program_sequencer seq_checker #(.WORDS(WORDS), .ERASE_PULSE_US(ERASE_PULSE_US),
   .WRITE_PULSE_US(WRITE_PULSE_US)) chk_u (
   .clk, .rst_n, .rd_req, .busy, .done, .fail, .rd_valid, .rd_data, .arr_rdata, .arr_addr, .arr_mode,
   .arr_erase_pulse, .arr_write_pulse, .arr_fwrite_pulse, .arr_zero_mask, .arr_seg_en, .cycles_per_us);
`default_nettype wire
